// ===== design/isa_id_pkg.sv
// constants for the instruction set identification register
package isa_id_pkg;

    // ------------------------------------------------------------
    // register geometry
    // ------------------------------------------------------------
    localparam int reg_width = 64;
    localparam int field_width = 4;

    // ------------------------------------------------------------
    // field positions (low bit of each nibble)
    // ------------------------------------------------------------
    localparam int pos_random_number = 60;
    localparam int pos_tlb_maint = 56;
    localparam int pos_flag_manipulation = 52;
    localparam int pos_half_widening_mac = 48;
    localparam int pos_dot_product = 44;
    localparam int pos_national_block_cipher = 40;
    localparam int pos_national_hash = 36;
    localparam int pos_sha3 = 32;
    localparam int pos_rounding_doubling_mac = 28;
    localparam int pos_transactional_memory = 24;
    localparam int pos_atomic = 20;
    localparam int pos_crc32 = 16;
    localparam int pos_sha2 = 12;
    localparam int pos_sha1 = 8;
    localparam int pos_aes = 4;
    localparam int pos_reserved = 0;

    // ------------------------------------------------------------
    // field values
    // ------------------------------------------------------------
    localparam logic [3:0] val_absent = 4'h0;
    localparam logic [3:0] val_tlb_maint = 4'h2;
    localparam logic [3:0] val_flag_manipulation = 4'h2;
    localparam logic [3:0] val_half_widening_mac = 4'h1;
    localparam logic [3:0] val_dot_product = 4'h1;
    localparam logic [3:0] val_national_block_cipher = 4'h1;
    localparam logic [3:0] val_national_hash = 4'h1;
    localparam logic [3:0] val_sha3 = 4'h1;
    localparam logic [3:0] val_rounding_doubling_mac = 4'h1;
    localparam logic [3:0] val_atomic = 4'h2;
    localparam logic [3:0] val_crc32 = 4'h1;
    localparam logic [3:0] val_sha2 = 4'h2;
    localparam logic [3:0] val_sha1 = 4'h1;
    localparam logic [3:0] val_aes = 4'h2;

    // ------------------------------------------------------------
    // access outcome
    // ------------------------------------------------------------
    localparam logic [5:0] syndrome_sys_access = 6'h18;

    typedef enum logic [1:0] {
        level_user = 2'h0,
        level_kernel = 2'h1,
        level_hyp = 2'h2,
        level_monitor = 2'h3
    } level_type;

endpackage : isa_id_pkg

// ===== design/isa_access_check.sv
// privilege check deciding between return and trap for a register read
`timescale 1ns/10ps
module isa_access_check
    import isa_id_pkg::*;
(
    input wire logic [1:0] level,
    input wire logic hyp_enabled,
    input wire logic hyp_trap_general_bit,
    input wire logic hyp_id_group3_trap_bit,
    output logic trap,
    output logic [1:0] trap_level
);

    // ------------------------------------------------------------
    // decision per current level
    // ------------------------------------------------------------
    always_comb begin
        trap = 1'b0;
        trap_level = level_kernel;
        case (level_type'(level))
            level_user: begin
                trap = 1'b1;
                if (hyp_enabled && hyp_trap_general_bit) begin
                    trap_level = level_hyp;
                end
            end
            level_kernel: begin
                if (hyp_enabled && hyp_id_group3_trap_bit) begin
                    trap = 1'b1;
                    trap_level = level_hyp;
                end
            end
            default: begin
                trap = 1'b0;
            end
        endcase
    end

endmodule : isa_access_check

// ===== design/isa_feature_id_register.sv
// instruction set identification register with read access control
`timescale 1ns/10ps
// What this block does
// - Provide a 64-bit read-only identification register readable by system-register read.
// - Bits 63:60 read zero: no random number instructions.
// - Bits 59:56 read 0010: outer-shareable and range cache maintenance.
// - Bits 55:52 read 0010: full flag manipulation set.
// - Bits 51:48 read 0001: half-precision widening multiply-accumulate.
// - Bits 47:44 read 0001: signed and unsigned dot product.
// - Bits 43:40 read 0001 with cryptography on, else 0000.
// - Bits 39:36 read 0001 with cryptography on, else 0000.
// - Bits 35:32 read 0001 with cryptography on, else zero.
// - Bits 31:28 read 0001: rounding doubling multiply-accumulate.
// - Bits 27:24 read zero: no transactional memory.
// - Bits 23:20 read 0010: full atomic instruction set.
// - Bits 19:16 read 0001: all CRC32 instructions.
// - Bits 15:12 read 0010 with cryptography on, else 0000.
// - Bits 11:8 read 0001 with cryptography on, else 0000.
// - Bits 7:4 read 0010 with cryptography on, else 0000.
// - Bits 3:0 reserved, read zero.
// - Cryptography on only if build option true and disable low at reset.
// - User-level read traps, class 0x18, to hypervisor if general trap set, else kernel.
// - Kernel read traps to hypervisor if group-3 trap set, else returns value.
// - Hypervisor and monitor reads always return the value.
// - Disable input turns cryptography off only if high while reset is held; later changes are ignored.
module isa_feature_id_register
    import isa_id_pkg::*;
#(
    parameter bit cipher_build_option = 1'b1
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cipher_disable_input,
    input wire logic read_req,
    input wire logic [1:0] level,
    input wire logic hyp_enabled,
    input wire logic hyp_trap_general_bit,
    input wire logic hyp_id_group3_trap_bit,
    output logic read_done,
    output logic [reg_width-1:0] read_data,
    output logic trap_taken,
    output logic [1:0] trap_target,
    output logic [5:0] trap_syndrome,
    output logic cipher_enabled
);

    // ------------------------------------------------------------
    // field table, one entry per nibble, lowest nibble first
    // ------------------------------------------------------------
    localparam int field_count = reg_width / field_width;

    // low bit of each field, checked against its slot below
    localparam int field_pos [field_count] = '{
        // bits 3:0
        pos_reserved,
        // bits 7:4
        pos_aes,
        // bits 11:8
        pos_sha1,
        // bits 15:12
        pos_sha2,
        // bits 19:16
        pos_crc32,
        // bits 23:20
        pos_atomic,
        // bits 27:24
        pos_transactional_memory,
        // bits 31:28
        pos_rounding_doubling_mac,
        // bits 35:32
        pos_sha3,
        // bits 39:36
        pos_national_hash,
        // bits 43:40
        pos_national_block_cipher,
        // bits 47:44
        pos_dot_product,
        // bits 51:48
        pos_half_widening_mac,
        // bits 55:52
        pos_flag_manipulation,
        // bits 59:56
        pos_tlb_maint,
        // bits 63:60
        pos_random_number
    };

    // value each field reports while cryptography is on
    localparam logic [field_width-1:0] field_value [field_count] = '{
        // reserved nibble
        val_absent,
        // block cipher rounds and wide polynomial multiply
        val_aes,
        // first-generation hash
        val_sha1,
        // 256 and 512 bit hash
        val_sha2,
        // cyclic redundancy check, both polynomials
        val_crc32,
        // full atomic set
        val_atomic,
        // no transactional memory
        val_absent,
        // rounding doubling multiply-accumulate
        val_rounding_doubling_mac,
        // three-way xor, rotate-xor, bit-clear-xor
        val_sha3,
        // national hash
        val_national_hash,
        // national block cipher
        val_national_block_cipher,
        // signed and unsigned dot product
        val_dot_product,
        // half-precision widening multiply-accumulate
        val_half_widening_mac,
        // flag inversion, rotate and format conversion
        val_flag_manipulation,
        // outer-shareable and range cache maintenance
        val_tlb_maint,
        // no random number instructions
        val_absent
    };

    // fields that fall back to absent when cryptography is off
    localparam bit field_gated [field_count] = '{
        1'b0, // reserved
        1'b1, // aes
        1'b1, // sha1
        1'b1, // sha2
        1'b0, // crc32
        1'b0, // atomic
        1'b0, // transactional memory
        1'b0, // rounding doubling mac
        1'b1, // sha3
        1'b1, // national hash
        1'b1, // national block cipher
        1'b0, // dot product
        1'b0, // half widening mac
        1'b0, // flag manipulation
        1'b0, // tlb maintenance
        1'b0 // random number
    };

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the image is built from whole nibbles only
    if (reg_width % field_width != 0) begin : bad_reg_width
        $error("register width is not a whole number of fields");
    end

    // the reserved nibble must always read zero
    if (field_value[pos_reserved / field_width] != val_absent) begin : bad_reserved
        $error("reserved field must read zero");
    end

    // the syndrome constant must fill the syndrome output exactly
    if ($bits(syndrome_sys_access) != $bits(trap_syndrome)) begin : bad_syndrome
        $error("syndrome constant does not match the syndrome output");
    end

    // each entry in its own slot, else two drivers meet on one nibble
    for (genvar f = 0; f < field_count; f++) begin : slot_check
        if (field_pos[f] != f * field_width) begin : bad_slot
            $error("field position does not match its table slot");
        end
        if (field_pos[f] + field_width > reg_width) begin : bad_range
            $error("field runs past the top of the register");
        end
        if (field_gated[f] && field_value[f] == val_absent) begin : bad_gate
            $error("gated field would look absent with cryptography on");
        end
    end

    // ------------------------------------------------------------
    // disable pin synchroniser
    // ------------------------------------------------------------
    logic disable_meta;
    logic disable_sync;

    // two flops before anyone looks at the pin
    always_ff @(posedge clk) begin
        disable_meta <= cipher_disable_input;
        disable_sync <= disable_meta;
    end

    // ------------------------------------------------------------
    // cryptography state caught at reset
    // ------------------------------------------------------------
    logic cipher_on;

    // sampled while reset is held, frozen afterwards
    always_ff @(posedge clk) begin
        if (srst) begin
            cipher_on <= cipher_build_option && !disable_sync;
        end
    end

    // ------------------------------------------------------------
    // register image
    // ------------------------------------------------------------
    logic [reg_width-1:0] id_image;

    // one nibble per table entry, gated ones drop to absent with cryptography off
    for (genvar f = 0; f < field_count; f++) begin : image_field
        if (field_gated[f]) begin : gated
            assign id_image[field_pos[f] +: field_width] =
                cipher_on ? field_value[f] : val_absent;
        end else begin : fixed
            assign id_image[field_pos[f] +: field_width] = field_value[f];
        end
    end

    // ------------------------------------------------------------
    // access check
    // ------------------------------------------------------------
    logic next_trap;
    logic [1:0] next_trap_level;

    isa_access_check access_check (
        .level(level),
        .hyp_enabled(hyp_enabled),
        .hyp_trap_general_bit(hyp_trap_general_bit),
        .hyp_id_group3_trap_bit(hyp_id_group3_trap_bit),
        .trap(next_trap),
        .trap_level(next_trap_level)
    );

    // ------------------------------------------------------------
    // read answer, one cycle after the request
    // ------------------------------------------------------------
    logic read_trapped;
    logic read_returned;

    // a taken read either traps or returns the image
    assign read_trapped = read_req && next_trap;
    assign read_returned = read_req && !next_trap;

    // answer strobe, one pulse per taken read
    always_ff @(posedge clk) begin
        if (srst) begin
            read_done <= 1'b0;
        end else begin
            read_done <= read_req;
        end
    end

    // trap strobe travels with the answer strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            trap_taken <= 1'b0;
        end else begin
            trap_taken <= read_trapped;
        end
    end

    // data holds between reads, trapped reads show nothing
    always_ff @(posedge clk) begin
        if (srst) begin
            read_data <= '0;
        end else if (read_trapped) begin
            read_data <= '0;
        end else if (read_returned) begin
            read_data <= id_image;
        end
    end

    // trap target only moves on a trap
    always_ff @(posedge clk) begin
        if (srst) begin
            trap_target <= level_kernel;
        end else if (read_trapped) begin
            trap_target <= next_trap_level;
        end
    end

    // syndrome class on a trap, cleared on a returned read
    always_ff @(posedge clk) begin
        if (srst) begin
            trap_syndrome <= '0;
        end else if (read_trapped) begin
            trap_syndrome <= syndrome_sys_access;
        end else if (read_returned) begin
            trap_syndrome <= '0;
        end
    end

    // ------------------------------------------------------------
    // cryptography status
    // ------------------------------------------------------------
    // status copy of the reset-time decision
    always_ff @(posedge clk) begin
        if (srst) begin
            cipher_enabled <= 1'b0;
        end else begin
            cipher_enabled <= cipher_on;
        end
    end

endmodule : isa_feature_id_register

// ===== test/id_register_sva.sv
// checker for the identification register read port
`timescale 1ns/10ps
module id_register_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic cipher_disable_input,
    input wire logic read_req,
    input wire logic [1:0] level,
    input wire logic hyp_enabled,
    input wire logic hyp_trap_general_bit,
    input wire logic hyp_id_group3_trap_bit,
    input wire logic read_done,
    input wire logic [63:0] read_data,
    input wire logic trap_taken,
    input wire logic [1:0] trap_target,
    input wire logic [5:0] trap_syndrome,
    input wire logic cipher_enabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // read handshake and access control
    // ----------------------------------------
    chk_done_one_cycle: assert property (read_req |=> read_done)
        else $error("read answer missing");
    chk_no_spurious_done: assert property (!read_req |=> !read_done)
        else $error("answer without request");
    chk_user_read_trap: assert property (read_req && level == 2'h0 |=> trap_taken
        && trap_syndrome == 6'h18 && read_data == 64'h0
        && trap_target == ($past(hyp_enabled) && $past(hyp_trap_general_bit) ? 2'h2 : 2'h1))
        else $error("user read trap wrong");
    chk_kernel_read_trap: assert property (read_req && level == 2'h1
        |=> trap_taken == ($past(hyp_enabled) && $past(hyp_id_group3_trap_bit)))
        else $error("kernel read trap wrong");
    chk_high_never_traps: assert property (read_req && level[1]
        |=> !trap_taken && trap_syndrome == 6'h0)
        else $error("high level read trapped");
    chk_trap_with_done: assert property (trap_taken |-> read_done)
        else $error("trap without answer");
    // ----------------------------------------
    // register image
    // ----------------------------------------
    chk_middle_fields: assert property (read_done && !trap_taken
        |-> read_data[31:16] == 16'h1021)
        else $error("middle fields wrong");
    chk_fixed_fields: assert property (read_done && !trap_taken
        |-> read_data[63:44] == 20'h02211 && read_data[31:16] == 16'h1021
        && read_data[3:0] == 4'h0)
        else $error("fixed fields wrong");
    chk_cipher_fields: assert property (
        read_done && !trap_taken
        |-> read_data[43:32] == (cipher_enabled ? 12'h111 : 12'h000)
        && read_data[15:4] == (cipher_enabled ? 12'h212 : 12'h000))
        else $error("cipher fields wrong");
    chk_cipher_held: assert property (!$past(srst) && !$past(srst, 2)
        |-> $stable(cipher_enabled))
        else $error("cipher state moved");
    cov_user_trap: cover property (read_req && level == 2'h0 ##1 trap_taken);
    cov_kernel_value: cover property (read_req && level == 2'h1 ##1 !trap_taken);
    cov_cipher_off_read: cover property (read_done && !cipher_enabled);
endmodule : id_register_checker

bind isa_feature_id_register id_register_checker i_chk (.clk(clk), .srst(srst),
    .cipher_disable_input(cipher_disable_input), .read_req(read_req), .level(level),
    .hyp_enabled(hyp_enabled), .hyp_trap_general_bit(hyp_trap_general_bit),
    .hyp_id_group3_trap_bit(hyp_id_group3_trap_bit), .read_done(read_done),
    .read_data(read_data), .trap_taken(trap_taken), .trap_target(trap_target),
    .trap_syndrome(trap_syndrome), .cipher_enabled(cipher_enabled));

// ===== test/tb_top.sv
// self-checking bench for the identification register
`timescale 1ns/10ps
module tb_top;
    import isa_id_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cipher_disable_input = 1'b0;
    logic read_req = 1'b0;
    logic [1:0] level = 2'h0;
    logic hyp_enabled = 1'b0;
    logic hyp_trap_general_bit = 1'b0;
    logic hyp_id_group3_trap_bit = 1'b0;
    logic read_done, trap_taken, cipher_enabled, cipher_build_option_on;
    logic [63:0] read_data;
    logic [1:0] trap_target;
    logic [5:0] trap_syndrome;
    logic [72:0] notes[$];
    logic [72:0] got, expd;
    logic [15:0] rnd = 16'hfb66;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    isa_feature_id_register i_dut (.clk(clk), .srst(srst),
        .cipher_disable_input(cipher_disable_input), .read_req(read_req), .level(level),
        .hyp_enabled(hyp_enabled), .hyp_trap_general_bit(hyp_trap_general_bit),
        .hyp_id_group3_trap_bit(hyp_id_group3_trap_bit), .read_done(read_done),
        .read_data(read_data), .trap_taken(trap_taken), .trap_target(trap_target),
        .trap_syndrome(trap_syndrome), .cipher_enabled(cipher_enabled));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // expected answer: {trap, target, syndrome, data}
    function automatic logic [72:0] expect_read(input logic [1:0] lv, input logic he, tge,
        tid3, ce);
        logic tr;
        logic [1:0] tg;
        tr = (lv == 2'h0) || (lv == 2'h1 && he && tid3);
        tg = (lv == 2'h0 && !(he && tge)) ? 2'h1 : 2'h2;
        if (tr) return {1'b1, tg, 6'h18, 64'h0};
        return {9'h0, ce ? 64'h0221_1111_1021_2120 : 64'h0221_1000_1021_0000};
    endfunction : expect_read

    task automatic cmp(input string name, input logic [72:0] e, input logic [72:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask : cmp

    task automatic cmp_flag(input string name, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %b seen %b", name, e, g);
        end
    endtask : cmp_flag

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    // random reads, mostly back to back, noting each expected answer
    task automatic run_reads(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rnd = lfsr_next(rnd);
            read_req = rnd[0] | rnd[1];
            level = rnd[3:2];
            hyp_enabled = rnd[4];
            hyp_trap_general_bit = rnd[5];
            hyp_id_group3_trap_bit = rnd[6];
            if (read_req) notes.push_back(expect_read(level, hyp_enabled,
                hyp_trap_general_bit, hyp_id_group3_trap_bit, cipher_build_option_on));
        end
        @(negedge clk);
        read_req = 1'b0;
    endtask : run_reads

    // watcher: compare each answer with the oldest note, away from the launching edge
    always @(negedge clk) begin
        if (read_done === 1'b1) begin
            got = {trap_taken, trap_target, trap_syndrome, read_data};
            expd = (notes.size() > 0) ? notes.pop_front() : 73'h0;
            if (expd[72] !== 1'b1) got[71:70] = 2'h0;
            cmp("read_result", expd, got);
        end
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        cipher_build_option_on = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        run_reads(40);
        cmp_flag("cipher_enabled", 1'b1, cipher_enabled);
        cipher_disable_input = 1'b1;
        run_reads(10);
        cmp_flag("cipher_enabled", 1'b1, cipher_enabled);
        srst = 1'b1;
        cipher_build_option_on = 1'b0;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        cipher_disable_input = 1'b0;
        run_reads(40);
        cmp_flag("cipher_enabled", 1'b0, cipher_enabled);
        repeat (3) @(negedge clk);
        cmp("pending_reads", 73'h0, 73'(notes.size()));
        report_and_stop();
    end
endmodule : tb_top
